// File: design/lsp_cmd_mem.sv
// Command register store with registered read data
`timescale 1ns/1ps
module lsp_cmd_mem
    import lsp_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
)
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Access port
    lsp_mem_if.store bus
);
    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] cells;
        logic [DATA_W-1:0] rdata;
    } lsp_mem_state_t;

    lsp_mem_state_t st;
    lsp_mem_state_t next_st;

    assign bus.rdata = st.rdata;

    always_comb
    begin
        next_st = st;
        if (bus.we)
        begin
            next_st.cells[bus.addr] = bus.wdata;
        end
        // Read always follows the address, one cycle late
        next_st.rdata = st.cells[bus.addr];
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// File: design/lsp_fifo.sv
// Small FIFO between the receive decoder and the recovered-data outputs
`timescale 1ns/1ps
module lsp_fifo
    import lsp_pkg::*;
#(
    parameter int WIDTH = RX_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Both sides
    lsp_fifo_if.buffer f
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW:0] count;
    } lsp_fifo_state_t;

    lsp_fifo_state_t st;
    lsp_fifo_state_t next_st;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign f.in_ready = (st.count != (PW+1)'(DEPTH));
    assign f.out_valid = (st.count != '0);
    assign f.out_data = st.cells[st.rptr];
    assign push = f.in_valid && f.in_ready;
    assign pop = f.out_valid && f.out_ready;

    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.cells[st.wptr] = f.in_data;
            next_st.wptr = bump(st.wptr);
        end
        if (pop)
        begin
            next_st.rptr = bump(st.rptr);
        end
        next_st.count = st.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// File: design/lsp_ifs.sv
// Internal carriers: command store port and receive FIFO port
`timescale 1ns/1ps
interface lsp_mem_if #(parameter int AW = 5, parameter int DW = 8);
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport user (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface

interface lsp_fifo_if #(parameter int W = 3);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport user (output in_valid, output in_data, input in_ready, input out_valid, input out_data, output out_ready);
    modport buffer (input in_valid, input in_data, output in_ready, output out_valid, output out_data, input out_ready);
endinterface

// File: design/lsp_pkg.sv
// Shared constants and types for the line serial port and pin controls
package lsp_pkg;
    // Serial command frame: direction bit, then address, then data, MSB first
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 32;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ADDR_END = CNT_W'(1 + ADDR_W);
    localparam logic [CNT_W-1:0] CNT_END = CNT_W'(1 + ADDR_W + DATA_W);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ADDR_W + DATA_W);
    localparam logic RW_READ = 1'b1;
    // Control shadow register inside the command store
    localparam logic [ADDR_W-1:0] CTL_ADDR = 5'h00;
    localparam int CTL_MUTE_BIT = 0;
    localparam int CTL_BYPASS_BIT = 1;
    localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;
    // Zero-substitution run lengths
    localparam int B3ZS_RUN = 3;
    localparam int HDB3_RUN = 4;
    localparam int WIN_LEN = 4;
    // Receive word {violation, positive, negative}
    localparam int FIFO_DEPTH = 4;
    localparam int RX_W = 3;
    localparam int RX_LCV = 2;
    localparam int RX_POS = 1;
    localparam int RX_NEG = 0;
    // Synchronised pin indices
    localparam int PIN_N = 6;
    localparam int PIN_MODE = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_SCLK = 2;
    localparam int PIN_SDI = 3;
    localparam int PIN_LOS = 4;
    localparam int PIN_E3 = 5;
    typedef enum logic [1:0] {SYM_ZERO, SYM_MARK, SYM_VIOL, SYM_BAL} lsp_sym_t;
endpackage

// File: design/lsp_top.sv
// Shared serial-port / hardware-control pins with line codec and receive path
//
// Functional notes
// R1: Serial input captured on serial clock rising edges
// R2: Host sends direction, address, then write data
// R3: Read data changes only on serial clock falls
// R4: Data output released after transfer completes
// R5: Mute on, signal loss: both rails low
// R6: Mute off: rails keep data during loss
// R7: Violation pin pulses high one bit period
// R8: Codec bypass high: plain AMI both directions
// R9: Codec bypass low: B3ZS or HDB3 substitution
// R10: Mode select high serial port, low pins
// R11: Chip select high: serial clock/data ignored
// R12: Frame order direction, address, data; MSB first
`timescale 1ns/1ps
module lsp_top
    import lsp_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Shared pins and mode strap
    input wire logic i_port_mode_select,
    input wire logic i_chip_select_b,
    input wire logic i_serial_clock,
    input wire logic i_serial_in_line,
    output logic o_serial_out_line,
    output logic o_serial_out_line_oe_b,
    // Line status and rate
    input wire logic i_signal_loss_condition,
    input wire logic i_e3_select,
    // Receive path
    input wire logic i_rx_line_pos,
    input wire logic i_rx_line_neg,
    input wire logic i_rx_bit_strobe,
    input wire logic i_rx_out_strobe,
    output logic o_recovered_positive_rail,
    output logic o_recovered_negative_rail,
    output logic o_rx_accept_ready,
    // Transmit path
    input wire logic i_tx_data,
    input wire logic i_tx_bit_strobe,
    output logic o_tx_line_pos,
    output logic o_tx_line_neg
);
    typedef struct packed {
        logic [PIN_N-1:0] sync1;
        logic [PIN_N-1:0] sync2;
        logic sclk_prev;
        logic [CNT_W-1:0] bit_cnt;
        logic rw;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] shift_in;
        logic [DATA_W-1:0] shift_out;
        logic [1:0] load_wait;
        logic mem_we;
        logic [DATA_W-1:0] ctl;
        logic pin_out;
        logic pin_oe_b;
        logic [WIN_LEN-1:0][RX_W-1:0] rx_win;
        logic rx_last;
        logic [RX_W-1:0] rx_raw;
        logic recovered_positive_rail;
        logic recovered_negative_rail;
        logic lcv_out;
        logic rx_rdy;
        lsp_sym_t [WIN_LEN-1:0] tx_win;
        logic tx_par;
        logic tx_last;
        logic tx_pos;
        logic tx_neg;
    } lsp_state_t;

    lsp_state_t st;
    lsp_state_t next_st;
    logic host;
    logic cs_on;
    logic sclk_rise;
    logic sclk_fall;
    logic mute_on;
    logic bypass;
    logic signal_loss_condition;
    int run;
    logic rx_push;
    logic [RX_W-1:0] rx_word;

    lsp_mem_if #(.AW(ADDR_W), .DW(DATA_W)) mem ();
    lsp_fifo_if #(.W(RX_W)) rxq ();

    lsp_cmd_mem #(.DEPTH(MEM_DEPTH)) u_mem (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .bus(mem.store)
    );

    lsp_fifo #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .f(rxq.buffer)
    );

    assign host = st.sync2[PIN_MODE]; // R10
    assign cs_on = host && !st.sync2[PIN_CS]; // R11
    assign sclk_rise = st.sync2[PIN_SCLK] && !st.sclk_prev;
    assign sclk_fall = !st.sync2[PIN_SCLK] && st.sclk_prev;
    // Pins double as controls only in hardware mode; host mode uses the shadow
    assign mute_on = host ? st.ctl[CTL_MUTE_BIT] : st.sync2[PIN_SDI];
    assign bypass = host ? st.ctl[CTL_BYPASS_BIT] : st.sync2[PIN_SCLK];
    assign signal_loss_condition = st.sync2[PIN_LOS];
    assign run = st.sync2[PIN_E3] ? HDB3_RUN : B3ZS_RUN;

    assign mem.we = st.mem_we;
    assign mem.addr = st.addr;
    assign mem.wdata = st.shift_in;
    assign rxq.in_valid = rx_push;
    assign rxq.in_data = rx_word;
    assign rxq.out_ready = i_rx_out_strobe;

    assign o_serial_out_line = st.pin_out;
    assign o_serial_out_line_oe_b = st.pin_oe_b;
    assign o_recovered_positive_rail = st.recovered_positive_rail;
    assign o_recovered_negative_rail = st.recovered_negative_rail;
    assign o_rx_accept_ready = st.rx_rdy;
    assign o_tx_line_pos = st.tx_pos;
    assign o_tx_line_neg = st.tx_neg;

    always_comb
    begin
        logic [WIN_LEN-1:0][RX_W-1:0] nwin;
        lsp_sym_t [WIN_LEN-1:0] twin;
        lsp_sym_t out_sym;
        logic pulse;
        logic viol;
        logic clean;
        logic zrun;
        logic pol;
        nwin = st.rx_win;
        twin = st.tx_win;
        out_sym = SYM_ZERO;
        pulse = 1'b0;
        viol = 1'b0;
        clean = 1'b0;
        zrun = 1'b0;
        pol = 1'b0;
        next_st = st;
        rx_push = 1'b0;
        rx_word = st.rx_win[run-1];

        // Mode, chip-select, serial clock/data, loss and E3 pins pass two flops before use; line and strobe inputs do not
        next_st.sync1 = {i_e3_select, i_signal_loss_condition, i_serial_in_line,
                         i_serial_clock, i_chip_select_b, i_port_mode_select};
        next_st.sync2 = st.sync1;
        next_st.sclk_prev = st.sync2[PIN_SCLK];
        next_st.mem_we = 1'b0;
        next_st.load_wait = {st.load_wait[0], 1'b0};
        next_st.rx_rdy = rxq.in_ready;

        if (st.mem_we && st.addr == CTL_ADDR)
        begin
            next_st.ctl = st.shift_in;
        end
        if (st.load_wait[1])
        begin
            next_st.shift_out = mem.rdata;
        end

        // Serial command port
        if (!cs_on)
        begin
            next_st.bit_cnt = '0; // R11
            next_st.pin_oe_b = 1'b1;
        end
        else
        begin
            if (sclk_rise && st.bit_cnt != CNT_END)
            begin
                next_st.bit_cnt = st.bit_cnt + 1'b1; // R1
                if (st.bit_cnt == '0)
                begin
                    next_st.rw = st.sync2[PIN_SDI]; // R12
                end
                else if (st.bit_cnt < CNT_ADDR_END)
                begin
                    next_st.addr = {st.addr[ADDR_W-2:0], st.sync2[PIN_SDI]}; // R12
                end
                else
                begin
                    next_st.shift_in = {st.shift_in[DATA_W-2:0], st.sync2[PIN_SDI]};
                end
                if (st.bit_cnt == CNT_ADDR_END - 1'b1 && st.rw == RW_READ)
                begin
                    next_st.load_wait[0] = 1'b1;
                end
                if (st.bit_cnt == CNT_LAST)
                begin
                    next_st.mem_we = (st.rw != RW_READ);
                    next_st.pin_oe_b = 1'b1; // R4
                end
            end
            if (sclk_fall && st.rw == RW_READ && st.bit_cnt >= CNT_ADDR_END && st.bit_cnt < CNT_END)
            begin
                next_st.pin_out = st.shift_out[DATA_W-1]; // R3
                next_st.shift_out = {st.shift_out[DATA_W-2:0], 1'b0};
                next_st.pin_oe_b = 1'b0;
            end
        end

        // Receive decoder; a strobe while the FIFO is full is dropped
        if (i_rx_bit_strobe && rxq.in_ready)
        begin
            rx_push = 1'b1;
            for (int i = WIN_LEN - 1; i > 0; i--)
            begin
                nwin[i] = st.rx_win[i-1];
            end
            nwin[0] = {i_rx_line_pos && i_rx_line_neg, i_rx_line_pos, i_rx_line_neg};
            pulse = i_rx_line_pos ^ i_rx_line_neg;
            viol = pulse && (i_rx_line_pos == st.rx_last);
            if (viol)
            begin
                clean = !bypass; // R8
                for (int i = 1; i < WIN_LEN - 1; i++)
                begin
                    if (i <= run - 2 && nwin[i][RX_POS:RX_NEG] != 2'h0)
                    begin
                        clean = 1'b0;
                    end
                end
                if (clean)
                begin
                    for (int i = 0; i < WIN_LEN; i++)
                    begin
                        if (i < run)
                        begin
                            nwin[i] = '0; // R9
                        end
                    end
                end
                else
                begin
                    nwin[0][RX_LCV] = 1'b1; // R7
                end
            end
            if (pulse)
            begin
                next_st.rx_last = i_rx_line_pos;
            end
            next_st.rx_win = nwin;
        end

        // Output side paced by its own strobe
        if (i_rx_out_strobe)
        begin
            next_st.rx_raw = rxq.out_valid ? rxq.out_data : '0;
        end
        next_st.recovered_positive_rail = next_st.rx_raw[RX_POS] && !(mute_on && signal_loss_condition); // R5 R6
        next_st.recovered_negative_rail = next_st.rx_raw[RX_NEG] && !(mute_on && signal_loss_condition); // R5 R6
        next_st.lcv_out = next_st.rx_raw[RX_LCV]; // R7

        if (!host)
        begin
            next_st.pin_out = next_st.lcv_out; // R10 R7
            next_st.pin_oe_b = 1'b0;
        end

        // Transmit encoder; run-length lookahead costs a few bits of latency
        if (i_tx_bit_strobe)
        begin
            out_sym = st.tx_win[run-1];
            for (int i = WIN_LEN - 1; i > 0; i--)
            begin
                twin[i] = st.tx_win[i-1];
            end
            twin[0] = i_tx_data ? SYM_MARK : SYM_ZERO;
            if (i_tx_data)
            begin
                next_st.tx_par = !st.tx_par;
            end
            zrun = 1'b1;
            for (int i = 0; i < WIN_LEN; i++)
            begin
                if (i < run && twin[i] != SYM_ZERO)
                begin
                    zrun = 1'b0;
                end
            end
            if (!bypass && zrun)
            begin
                twin[0] = SYM_VIOL; // R9
                if (!st.tx_par)
                begin
                    twin[run-1] = SYM_BAL;
                end
                next_st.tx_par = 1'b0;
            end
            next_st.tx_win = twin;
            case (out_sym)
                SYM_MARK, SYM_BAL:
                begin
                    pol = !st.tx_last;
                    next_st.tx_pos = pol;
                    next_st.tx_neg = !pol;
                    next_st.tx_last = pol;
                end
                SYM_VIOL:
                begin
                    next_st.tx_pos = st.tx_last;
                    next_st.tx_neg = !st.tx_last;
                end
                default:
                begin
                    next_st.tx_pos = 1'b0;
                    next_st.tx_neg = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st <= '0;
            st.pin_oe_b <= 1'b1;
            // Read as host and deselected until synced, so the pin is not driven early
            st.sync1[PIN_CS:PIN_MODE] <= 2'h3;
            st.sync2[PIN_CS:PIN_MODE] <= 2'h3;
            st.ctl <= CTL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    a_rw_capture: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R1
        (cs_on && sclk_rise && st.bit_cnt == '0) |=> (st.rw == $past(st.sync2[PIN_SDI])))
        else $error("direction bit not captured on rising edge");
    a_sdo_on_fall: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R3
        (host && $past(host) && !st.pin_oe_b && st.pin_out != $past(st.pin_out)) |-> $past(sclk_fall))
        else $error("serial output changed without a falling edge");
    a_sdo_release: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R4
        (cs_on && sclk_rise && st.bit_cnt == CNT_LAST) |=> st.pin_oe_b)
        else $error("serial output not released after frame");
    a_mute_low: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R5
        (!host && st.sync2[PIN_SDI] && signal_loss_condition) |=> (!st.recovered_positive_rail && !st.recovered_negative_rail))
        else $error("rails not muted during signal loss");
    a_no_mute: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R6
        (!host && !st.sync2[PIN_SDI]) |=> (st.recovered_positive_rail == st.rx_raw[RX_POS] && st.recovered_negative_rail == st.rx_raw[RX_NEG]))
        else $error("rails altered while mute disabled");
    a_lcv_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R7
        (!host && st.lcv_out && !i_rx_out_strobe) |=> st.lcv_out)
        else $error("violation pulse shorter than one bit period");
    a_lcv_on_pin: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R7
        (!host ##1 !host) |-> (st.pin_out == st.lcv_out && !st.pin_oe_b))
        else $error("violation flag not on shared pin");
    a_bypass_ami: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R8
        (bypass && i_tx_bit_strobe && i_tx_data) |=> (st.tx_win[0] == SYM_MARK))
        else $error("substitution made while codec bypassed");
    a_hdb3_sub: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R9
        (!bypass && i_tx_bit_strobe && !i_tx_data && run == HDB3_RUN && st.tx_win[0] == SYM_ZERO
         && st.tx_win[1] == SYM_ZERO && st.tx_win[2] == SYM_ZERO) |=> (st.tx_win[0] == SYM_VIOL))
        else $error("four zeros not substituted");
    a_hw_drives_pin: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R10
        (!host) |=> !st.pin_oe_b)
        else $error("shared output not driven in hardware mode");
    a_cs_ignores: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R11
        (host && st.sync2[PIN_CS]) |=> (st.bit_cnt == '0 && st.pin_oe_b))
        else $error("serial activity while deselected");
    a_write_commit: assert property (@(posedge i_clock) disable iff (!i_rst_b) // R12
        (cs_on && sclk_rise && st.bit_cnt == CNT_LAST && st.rw != RW_READ) |=> st.mem_we)
        else $error("write not committed at frame end");

    c_read_frame: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        cs_on && sclk_fall && st.rw == RW_READ && st.bit_cnt == CNT_ADDR_END);
    c_mute: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        !host && mute_on && signal_loss_condition && st.rx_raw[RX_POS]);
    c_substitution: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        st.tx_win[0] == SYM_VIOL);
    c_violation: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        !host && $rose(st.lcv_out));
endmodule

// File: verification/lsp_host_model.sv
// Host model driving the shared serial pins of the port
`timescale 1ns/1ps
module lsp_host_model
    import lsp_pkg::*;
(
    // Clock
    input wire logic i_clock,
    // Serial pins
    input wire logic i_serial_out_line,
    input wire logic i_serial_out_line_oe_b,
    output logic o_chip_select_b,
    output logic o_serial_clock,
    output logic o_serial_in_line
);
    // Serial clock starts low; outside frames set_pins drives it to the bypass level
    initial
    begin
        o_chip_select_b = 1'b1;
        o_serial_clock = 1'b0;
        o_serial_in_line = 1'b0;
    end

    // Hardware mode: the pins carry bypass and mute levels
    task automatic set_pins(input logic byp, input logic mute);
        @(posedge i_clock);
        o_chip_select_b <= 1'b1;
        o_serial_clock <= byp;
        o_serial_in_line <= mute;
    endtask

    // One frame at 160 ns per serial bit; sel low leaves chip select off
    task automatic frame(input logic rw, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        input logic sel, output logic [DATA_W-1:0] q, output logic drv);
        logic [ADDR_W+DATA_W:0] w;
        w = {rw, a, d};
        q = '0;
        drv = 1'b1;
        @(posedge i_clock);
        o_chip_select_b <= ~sel;
        repeat (4) @(posedge i_clock);
        for (int i = ADDR_W + DATA_W; i >= 0; i--)
        begin
            o_serial_in_line <= w[i];
            repeat (4) @(posedge i_clock);
            o_serial_clock <= 1'b1;
            repeat (2) @(posedge i_clock);
            // Mid high phase, well clear of the device's update after the fall
            if (rw == RW_READ && i < DATA_W)
            begin
                q[i] = i_serial_out_line;
                drv = drv & (i_serial_out_line_oe_b === 1'b0);
            end
            repeat (2) @(posedge i_clock);
            o_serial_clock <= 1'b0;
        end
        repeat (4) @(posedge i_clock);
        o_chip_select_b <= 1'b1;
        o_serial_in_line <= ~w[0];
        repeat (4) @(posedge i_clock);
    endtask
endmodule

// File: verification/test_lsp_top.sv
// Self-checking bench for the serial port and pin controls
`timescale 1ns/1ps
module test_lsp_top
    import lsp_pkg::*;
    ;
    logic clock, rst_b, mode, cs_b, sclk, serial_in_line, loss, e3, rx_pos, rx_neg, rx_stb, out_stb, tx_data, tx_stb;
    logic serial_out_line, sdo_oe_b, rec_pos, rec_neg, rx_ready, tx_pos, tx_neg;
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    always #10 clock = ~clock;

    lsp_top u_lsp_top (
        .i_clock(clock), .i_rst_b(rst_b), .i_port_mode_select(mode), .i_chip_select_b(cs_b),
        .i_serial_clock(sclk), .i_serial_in_line(serial_in_line), .o_serial_out_line(serial_out_line),
        .o_serial_out_line_oe_b(sdo_oe_b), .i_signal_loss_condition(loss), .i_e3_select(e3),
        .i_rx_line_pos(rx_pos), .i_rx_line_neg(rx_neg), .i_rx_bit_strobe(rx_stb), .i_rx_out_strobe(out_stb),
        .o_recovered_positive_rail(rec_pos), .o_recovered_negative_rail(rec_neg), .o_rx_accept_ready(rx_ready),
        .i_tx_data(tx_data), .i_tx_bit_strobe(tx_stb), .o_tx_line_pos(tx_pos), .o_tx_line_neg(tx_neg)
    );

    lsp_host_model u_lsp_host_model (
        .i_clock(clock), .i_serial_out_line(serial_out_line), .i_serial_out_line_oe_b(sdo_oe_b),
        .o_chip_select_b(cs_b), .o_serial_clock(sclk), .o_serial_in_line(serial_in_line)
    );

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole run needs about 1700 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            $display("MISMATCH at %0t: timeout", $time);
            close_out();
        end
    end

    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask

    task automatic push(input logic p, input logic n);
        @(posedge clock);
        rx_pos <= p;
        rx_neg <= n;
        rx_stb <= 1'b1;
        @(posedge clock);
        rx_stb <= 1'b0;
    endtask

    task automatic pop;
        @(posedge clock);
        out_stb <= 1'b1;
        @(posedge clock);
        out_stb <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] q;
        logic ok;
        u_lsp_host_model.frame(RW_READ, a, 8'h00, 1'b1, q, ok);
        check(q === exp, "read data");
        check(ok === 1'b1, "pin not driven in read");
        check(sdo_oe_b === 1'b1, "pin held after frame");
    endtask

    // Pulse, same polarity after two zeros, then opposite; a negative count skips the check
    task automatic rx_run(input logic byp, input logic mute, input logic lossv, input logic e3v, input int em,
        input int ev);
        int m;
        int v;
        m = 0;
        v = 0;
        u_lsp_host_model.set_pins(byp, mute);
        loss <= lossv;
        e3 <= e3v;
        repeat (6) @(posedge clock);
        for (int i = 0; i < 16; i++)
        begin
            push(i == 0 || i == 3, i == 4);
            pop();
            m += (rec_pos === 1'b1) + (rec_neg === 1'b1);
            v += (serial_out_line === 1'b1);
        end
        if (em >= 0)
            check(m == em, "recovered pulse count");
        if (ev >= 0)
            check(v == ev, "violation pulse count");
    endtask

    // Four marks then zeros; late zeros must come out as steady substitutions when en is nonzero, as no pulses when en is 0
    task automatic tx_run(input logic byp, input logic e3v, input int en);
        int n;
        int same;
        logic [1:0] s;
        logic [1:0] last;
        n = 0;
        same = 0;
        last = 2'b00;
        u_lsp_host_model.set_pins(byp, 1'b0);
        e3 <= e3v;
        repeat (6) @(posedge clock);
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clock);
            tx_data <= (i < 4);
            tx_stb <= 1'b1;
            @(posedge clock);
            tx_stb <= 1'b0;
            #1;
            s = {tx_pos, tx_neg};
            if (s !== 2'b00)
            begin
                n += (i >= 12);
                same += (s === last);
                last = s;
            end
        end
        check(n == en, "transmit pulse count");
        check((same > 0) == (en > 0), "transmit same-polarity pulses");
    endtask

    initial
    begin
        logic [ADDR_W-1:0] adr [3];
        logic [DATA_W-1:0] dat [3];
        logic [DATA_W-1:0] q;
        logic ok;
        adr = '{5'h05, 5'h06, 5'h1F};
        dat = '{8'hA5, 8'h3C, 8'h81};
        clock = 1'b0;
        mode = 1'b1;
        {rst_b, loss, e3, rx_pos, rx_neg, rx_stb, out_stb, tx_data, tx_stb} = '0;
        repeat (8) @(posedge clock);
        check(sdo_oe_b === 1'b1 && tx_pos === 1'b0, "reset levels");
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        check(sdo_oe_b === 1'b1, "idle host pin driven");
        for (int i = 0; i < 3; i++)
            u_lsp_host_model.frame(~RW_READ, adr[i], dat[i], 1'b1, q, ok);
        u_lsp_host_model.frame(~RW_READ, adr[0], 8'h00, 1'b0, q, ok);
        for (int i = 0; i < 3; i++)
            rd(adr[i], dat[i]);
        // Host mode takes the codec bypass from the control shadow
        u_lsp_host_model.frame(~RW_READ, CTL_ADDR, 8'h02, 1'b1, q, ok);
        tx_run(1'b0, 1'b0, 0);
        mode <= 1'b0;
        repeat (6) @(posedge clock);
        check(sdo_oe_b === 1'b0, "hardware pin not driven");
        tx_run(1'b1, 1'b0, 0);
        tx_run(1'b0, 1'b0, 8);
        tx_run(1'b0, 1'b1, 6);
        rx_run(1'b0, 1'b0, 1'b0, 1'b1, 1, 0);
        rx_run(1'b1, 1'b0, 1'b0, 1'b0, 3, 1);
        rx_run(1'b0, 1'b0, 1'b0, 1'b0, 2, 0);
        rx_run(1'b1, 1'b1, 1'b1, 1'b0, 0, 1);
        rx_run(1'b1, 1'b0, 1'b1, 1'b0, 3, 1);
        // Fill buffer with no pops, then drain past empty
        u_lsp_host_model.set_pins(1'b1, 1'b0);
        loss <= 1'b0;
        for (int i = 0; i < 10; i++)
            push(i[0], ~i[0]);
        repeat (2) @(posedge clock);
        check(rx_ready === 1'b0, "full buffer still ready");
        repeat (4) pop();
        check(rx_ready === 1'b1, "drained buffer not ready");
        check({rec_pos, rec_neg} === 2'b01, "last buffered word");
        pop();
        check({rec_pos, rec_neg} === 2'b00, "empty buffer rails");
        close_out();
    end
endmodule
